// ==== ufb_pkg.sv ====
// Constants for the fractional baud generator and interrupt-pin block
// Notes on behaviour
// - Normal mode: tx irq low while holding byte present; FIFO on: low above trigger.
// - Direction mode: tx irq high only when whole transmitter empty, or below trigger.
// - Rx irq low with no data, high with a byte; FIFO on: high above trigger.
// - One oscillator input feeds both channels; bus access is also clocked by that oscillator.
// - Prescaler ahead of generator divides by 1, or by 4 when modem-control bit 7 set.
// - Generator divides by 1 up to 65536 minus 1/16 in sixteenth steps.
// - Divided clock is the 16X or 8X sampling tick for transmitter and receiver.
// - Enhanced-mode bit 7 set selects 16X, clear selects 8X.
// - Reset divisor is one: low byte 01, high byte 00, fraction 0.
// - Low byte holds integer bits 7:0, high byte bits 15:8.
// - Only four fraction bits exist; code n adds n/16.
// - 8X mode with odd fraction may jitter bit times by 1/16; accepted.
// - FIFO-control bit 0 enables the FIFO; clear means single-byte holding.
// - Direction mode off after reset, enabled by feature-control bit 3.
// - With integer divisor zero, high byte reads device code, low byte reads revision.
package ufb_pkg;
    localparam logic [2:0] UFB_ADDR_DIV_LOW  = 3'h0;
    localparam logic [2:0] UFB_ADDR_DIV_HIGH = 3'h1;
    localparam logic [2:0] UFB_ADDR_DIV_FRAC = 3'h2;
    localparam logic [7:0] UFB_DIV_LOW_RST   = 8'h01;
    localparam logic [7:0] UFB_DIV_HIGH_RST  = 8'h00;
    localparam logic [3:0] UFB_DIV_FRAC_RST  = 4'h0;
    localparam int         UFB_PRESCALE_BIT  = 7;
    localparam int         UFB_SAMPLE16_BIT  = 7;
    localparam int         UFB_FIFO_EN_BIT   = 0;
    localparam int         UFB_DIR485_BIT    = 3;
    localparam logic [1:0] UFB_PRESCALE_MAX  = 2'h3;
    localparam logic [3:0] UFB_FRAC_STEPS_M1 = 4'hF;
endpackage

// ==== ufb_baud_gen.sv ====
// One channel's prescaler and fractional divider producing the sampling tick
`timescale 1ns/100ps
module ufb_baud_gen #(
    parameter int DIV_W = 16
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             prescaleBy4,
    input  wire logic [DIV_W-1:0] divInt,
    input  wire logic [3:0]       divFrac,
    output logic                  sampleTick
);
    logic [1:0]       preCnt_reg;
    logic [DIV_W-1:0] divCnt_reg;
    logic [3:0]       phase_reg;
    logic [4:0]       fracAcc_reg;
    logic [4:0]       fracSum;
    logic             preTick;
    logic             extraCycle;
    logic [DIV_W-1:0] periodEnd;

    // Prescaler tick every input cycle, or every fourth
    assign preTick = !prescaleBy4 || (preCnt_reg == ufb_pkg::UFB_PRESCALE_MAX);
    // Accumulator adds one stretched cycle per 16ths overflow, spread evenly
    assign fracSum = {1'b0, fracAcc_reg[3:0]} + {1'b0, divFrac};
    assign extraCycle = fracSum[4];
    // Integer zero is treated as one so the tick never stalls
    assign periodEnd = (divInt == '0) ? '0 : divInt - DIV_W'(1);
    assign sampleTick = preTick && (divCnt_reg >= periodEnd) && !(extraCycle && phase_reg == 4'h0 && divCnt_reg == periodEnd);

    // Divider counts prescaled ticks; one extra tick when fraction overflows
    always_ff @(posedge clock) begin
        if (rst) begin
            preCnt_reg  <= '0;
            divCnt_reg  <= '0;
            phase_reg   <= '0;
            fracAcc_reg <= '0;
        end else begin
            preCnt_reg <= prescaleBy4 ? preCnt_reg + 2'h1 : 2'h0;
            if (preTick) begin
                if (sampleTick) begin
                    divCnt_reg  <= '0;
                    phase_reg   <= '0;
                    fracAcc_reg <= fracSum;
                end else if (divCnt_reg >= periodEnd) begin
                    phase_reg <= 4'h1; // Stretch cycle in progress
                end else begin
                    divCnt_reg <= divCnt_reg + DIV_W'(1);
                end
            end
        end
    end
endmodule

// ==== ufb_top.sv ====
// Dual-channel fractional baud generator, divisor registers and interrupt pins
`timescale 1ns/100ps
module ufb_top #(
    parameter logic [7:0] DEVICE_CODE   = 8'h5C, // Value arbitrary
    parameter logic [7:0] REVISION_CODE = 8'h01, // Value arbitrary
    parameter int         LEVEL_W       = 7
) (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               busWrite,
    input  wire logic               chanSel,
    input  wire logic [2:0]         busAddr,
    input  wire logic [7:0]         busWrData,
    output logic [7:0]              busRdData,
    input  wire logic [1:0]         modemCtrlBit7,
    input  wire logic [1:0]         enhancedModeBit7,
    input  wire logic [1:0]         fifoEnable,
    input  wire logic [1:0]         dirCtrlEnable,
    input  wire logic [1:0]         holdingFull,
    input  wire logic [1:0]         txEmpty,
    input  wire logic [1:0]         rxHasData,
    input  wire logic [2*LEVEL_W-1:0] txLevel,
    input  wire logic [2*LEVEL_W-1:0] txTrigger,
    input  wire logic [2*LEVEL_W-1:0] rxLevel,
    input  wire logic [2*LEVEL_W-1:0] rxTrigger,
    output logic [1:0]              sampleTick,
    output logic [1:0]              sample16x,
    output logic                    irq_out_first_channel,
    output logic                    irq_out_second_channel
);
    logic [7:0] divLow_reg  [2];
    logic [7:0] divHigh_reg [2];
    logic [3:0] divFrac_reg [2];
    logic [1:0] txIrq;
    logic [1:0] rxIrq;
    logic [1:0] irq_reg;
    logic [1:0] idMode;
    logic [1:0] wrLow;
    logic [1:0] wrHigh;
    logic [1:0] wrFrac;
    logic [7:0] rdLow;
    logic [7:0] rdHigh;
    logic [3:0] rdFrac;
    logic       ch;

    // Register access uses the shared oscillator clock; bus is strobe-per-cycle
    assign ch = chanSel;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gChan
            // Write decode for this channel
            assign wrLow[g]  = busWrite && (ch == 1'(g)) && (busAddr == ufb_pkg::UFB_ADDR_DIV_LOW);
            assign wrHigh[g] = busWrite && (ch == 1'(g)) && (busAddr == ufb_pkg::UFB_ADDR_DIV_HIGH);
            assign wrFrac[g] = busWrite && (ch == 1'(g)) && (busAddr == ufb_pkg::UFB_ADDR_DIV_FRAC);
            assign idMode[g] = (divLow_reg[g] == 8'h00) && (divHigh_reg[g] == 8'h00);

            // Divisor registers, reset to a divisor of one
            always_ff @(posedge clock) begin
                if (rst) begin
                    divLow_reg[g]  <= ufb_pkg::UFB_DIV_LOW_RST;
                    divHigh_reg[g] <= ufb_pkg::UFB_DIV_HIGH_RST;
                    divFrac_reg[g] <= ufb_pkg::UFB_DIV_FRAC_RST;
                end else begin
                    if (wrLow[g])  divLow_reg[g]  <= busWrData;
                    if (wrHigh[g]) divHigh_reg[g] <= busWrData;
                    if (wrFrac[g]) divFrac_reg[g] <= busWrData[3:0];
                end
            end

            // One generator per channel, all fed by the same oscillator clock
            ufb_baud_gen #(.DIV_W(16)) uGen (
                .clock       (clock),
                .rst         (rst),
                .prescaleBy4 (modemCtrlBit7[g]),
                .divInt      ({divHigh_reg[g], divLow_reg[g]}),
                .divFrac     (divFrac_reg[g]),
                .sampleTick  (sampleTick[g])
            );
            // Tick rate chooser: the consumer counts 16 or 8 ticks per bit; 8X odd fraction jitters
            assign sample16x[g] = enhancedModeBit7[g];

            // Transmit pin level
            assign txIrq[g] = !fifoEnable[g] ?
                (dirCtrlEnable[g] ? txEmpty[g] : !holdingFull[g]) :
                (dirCtrlEnable[g] ?
                    ((txLevel[g*LEVEL_W +: LEVEL_W] < txTrigger[g*LEVEL_W +: LEVEL_W]) || txEmpty[g]) :
                    (txLevel[g*LEVEL_W +: LEVEL_W] <= txTrigger[g*LEVEL_W +: LEVEL_W]));
            // Receive pin level
            assign rxIrq[g] = !fifoEnable[g] ? rxHasData[g] :
                (rxLevel[g*LEVEL_W +: LEVEL_W] > rxTrigger[g*LEVEL_W +: LEVEL_W]);

            // Registered pin so the output is glitch free
            always_ff @(posedge clock) begin
                if (rst) irq_reg[g] <= 1'b0;
                else     irq_reg[g] <= txIrq[g] | rxIrq[g];
            end
        end
    endgenerate

    // Read selection; direction mode bit is sampled by caller via dirCtrlEnable
    assign rdLow  = idMode[ch] ? REVISION_CODE : divLow_reg[ch];
    assign rdHigh = idMode[ch] ? DEVICE_CODE   : divHigh_reg[ch];
    assign rdFrac = divFrac_reg[ch];

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (rst) busRdData <= 8'h00;
        else case (busAddr)
            ufb_pkg::UFB_ADDR_DIV_LOW:  busRdData <= rdLow;
            ufb_pkg::UFB_ADDR_DIV_HIGH: busRdData <= rdHigh;
            ufb_pkg::UFB_ADDR_DIV_FRAC: busRdData <= {4'h0, rdFrac};
            default:                    busRdData <= 8'h00;
        endcase
    end

    assign irq_out_first_channel  = irq_reg[0];
    assign irq_out_second_channel = irq_reg[1];
endmodule

// ==== ufb_props.sv ====
// Checker for channel 0 interrupt pin, reset read and tick spacing
`timescale 1ns/100ps
module ufb_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [2:0] busAddr,
    input wire logic [7:0] busRdData,
    input wire logic [1:0] modemCtrlBit7,
    input wire logic [1:0] enhancedModeBit7,
    input wire logic [1:0] fifoEnable,
    input wire logic [1:0] dirCtrlEnable,
    input wire logic [1:0] holdingFull,
    input wire logic [1:0] txEmpty,
    input wire logic [1:0] rxHasData,
    input wire logic [1:0] sampleTick,
    input wire logic [1:0] sample16x,
    input wire logic       irq_out_first_channel
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // No FIFO and no receive byte, so only the transmit side drives the pin
    wire plain = !fifoEnable[0] && !rxHasData[0];
    property p_txIdle; plain && !dirCtrlEnable[0] && !holdingFull[0] |=> irq_out_first_channel; endproperty
    a_txIdle: assert property (p_txIdle) else $error("irq low with empty holding");
    property p_txHeld; plain && !dirCtrlEnable[0] && holdingFull[0] |=> !irq_out_first_channel; endproperty
    a_txHeld: assert property (p_txHeld) else $error("irq high with held byte");
    property p_dirBusy; plain && dirCtrlEnable[0] && !txEmpty[0] |=> !irq_out_first_channel; endproperty
    a_dirBusy: assert property (p_dirBusy) else $error("irq high while shifting");
    property p_dirDone; plain && dirCtrlEnable[0] && txEmpty[0] |=> irq_out_first_channel; endproperty
    a_dirDone: assert property (p_dirDone) else $error("irq low with idle transmitter");
    property p_rxByte; !fifoEnable[0] && rxHasData[0] |=> irq_out_first_channel; endproperty
    a_rxByte: assert property (p_rxByte) else $error("irq low with receive byte");
    property p_mode16; enhancedModeBit7 == $past(enhancedModeBit7) |-> sample16x == enhancedModeBit7; endproperty
    a_mode16: assert property (p_mode16) else $error("sampling rate flag wrong");
    // Guarded by the bit being set now and eight cycles earlier, so a prescale switch mid-count is not judged
    property p_pre4; sampleTick[0] && modemCtrlBit7[0] && $past(modemCtrlBit7[0], 8) |=> !sampleTick[0] [*3]; endproperty
    a_pre4: assert property (p_pre4) else $error("tick closer than prescale");
    property p_rstRead; $past(rst) && busAddr == 3'h0 |=> busRdData == 8'h01; endproperty
    a_rstRead: assert property (p_rstRead) else $error("low byte not one after reset");
    cover property (sampleTick[0] && modemCtrlBit7[0]);
    cover property (plain && dirCtrlEnable[0] && txEmpty[0]);
    cover property (fifoEnable[0] && irq_out_first_channel);
endmodule
bind ufb_top ufb_props u_props (.clock(clock), .rst(rst), .busAddr(busAddr), .busRdData(busRdData),
    .modemCtrlBit7(modemCtrlBit7), .enhancedModeBit7(enhancedModeBit7), .fifoEnable(fifoEnable),
    .dirCtrlEnable(dirCtrlEnable), .holdingFull(holdingFull), .txEmpty(txEmpty), .rxHasData(rxHasData),
    .sampleTick(sampleTick), .sample16x(sample16x), .irq_out_first_channel(irq_out_first_channel));

// ==== ufb_host.sv ====
// Host model issuing register bus transfers
`timescale 1ns/100ps
module ufb_host (
    input  wire logic       clock,
    output logic            busWrite,
    output logic            chanSel,
    output logic [2:0]      busAddr,
    output logic [7:0]      busWrData,
    input  wire logic [7:0] busRdData
);
    initial {busWrite, chanSel, busAddr, busWrData} = 13'h0000;
    // One transfer per call; stale write data is inverted so it never looks valid
    task automatic xfer(input logic we, ch, input logic [2:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clock);
        {chanSel, busAddr, busWrData, busWrite} <= {ch, a, wd, we};
        @(posedge clock);
        {busWrite, busWrData} <= {1'b0, ~wd};
        @(negedge clock);
        rd = busRdData;
    endtask
endmodule

// ==== test_ufb_top.sv ====
// Testbench for the divisor registers, sampling ticks and interrupt pins
`timescale 1ns/100ps
module test_ufb_top;
    logic       clock = 1'b0, rst = 1'b1, busWrite, chanSel, irqA, irqB;
    logic [1:0] modemCtrlBit7 = 2'h0, enhancedModeBit7 = 2'h0, fifoEnable = 2'h0, dirCtrlEnable = 2'h0;
    logic [1:0] holdingFull = 2'h0, txEmpty = 2'h0, rxHasData = 2'h0, sampleTick, sample16x;
    logic [13:0] txLevel = 14'h0000, txTrigger = 14'h0000, rxLevel = 14'h0000, rxTrigger = 14'h0000;
    logic [2:0] busAddr;
    logic [7:0] busWrData, busRdData, d;
    int         errors = 0, total_checks = 0, c;
    always #5 clock = ~clock;
    ufb_host host (.clock(clock), .busWrite(busWrite), .chanSel(chanSel), .busAddr(busAddr),
        .busWrData(busWrData), .busRdData(busRdData));
    ufb_top #(.DEVICE_CODE(8'h3B), .REVISION_CODE(8'h07)) DUT (.clock(clock), .rst(rst), .busWrite(busWrite),
        .chanSel(chanSel), .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData),
        .modemCtrlBit7(modemCtrlBit7), .enhancedModeBit7(enhancedModeBit7), .fifoEnable(fifoEnable),
        .dirCtrlEnable(dirCtrlEnable), .holdingFull(holdingFull), .txEmpty(txEmpty), .rxHasData(rxHasData),
        .txLevel(txLevel), .txTrigger(txTrigger), .rxLevel(rxLevel), .rxTrigger(rxTrigger),
        .sampleTick(sampleTick), .sample16x(sample16x), .irq_out_first_channel(irqA), .irq_out_second_channel(irqB));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] v);
        host.xfer(1'b1, ch, a, v, d);
    endtask
    task automatic rc(input logic ch, input logic [2:0] a, input logic [7:0] e);
        host.xfer(1'b0, ch, a, 8'h00, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    // Two ticks first, so a half-finished period after a change is skipped
    task automatic span(input int n, input logic [15:0] e);
        int k;
        k = 0;
        c = 0;
        repeat (2) do @(negedge clock); while (!sampleTick[0]);
        while (k < n) begin
            @(negedge clock);
            c++;
            if (sampleTick[0]) k++;
        end
        chk(c[15:0], e);
    endtask
    // Mask order: FIFO on, direction mode, holding full, transmitter empty, receive byte
    task automatic ic(input logic [4:0] m, input logic [6:0] tl, tt, rl, rt, input logic e);
        @(posedge clock);
        {fifoEnable[0], dirCtrlEnable[0], holdingFull[0], txEmpty[0], rxHasData[0]} <= m;
        {txLevel[6:0], txTrigger[6:0], rxLevel[6:0], rxTrigger[6:0]} <= {tl, tt, rl, rt};
        repeat (3) @(posedge clock);
        chk({15'h0000, irqA}, {15'h0000, e});
    endtask
    task automatic summarize();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            rc(ch[0], 3'h0, 8'h01);
            rc(ch[0], 3'h1, 8'h00);
            rc(ch[0], 3'h2, 8'h00);
        end
        wr(1'b0, 3'h0, 8'hFF); wr(1'b0, 3'h1, 8'hA5); wr(1'b0, 3'h2, 8'h3C);
        rc(1'b0, 3'h0, 8'hFF);
        rc(1'b0, 3'h1, 8'hA5);
        rc(1'b0, 3'h2, 8'h0C);
        rc(1'b1, 3'h1, 8'h00);
        rc(1'b0, 3'h5, 8'h00);
        wr(1'b1, 3'h0, 8'h00); wr(1'b1, 3'h1, 8'h00);
        rc(1'b1, 3'h1, 8'h3B);
        rc(1'b1, 3'h0, 8'h07);
        wr(1'b0, 3'h1, 8'h00); wr(1'b0, 3'h0, 8'h03); wr(1'b0, 3'h2, 8'h00);
        span(4, 16'h000C);
        @(posedge clock) modemCtrlBit7 <= 2'h1;
        span(2, 16'h0018);
        repeat (4) @(posedge clock);
        {modemCtrlBit7, enhancedModeBit7} <= 4'h2;
        wr(1'b0, 3'h0, 8'h02); wr(1'b0, 3'h2, 8'h08);
        span(16, 16'h0028);
        chk({14'h0000, sample16x}, 16'h0002);
        ic(5'b00100, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0);
        ic(5'b00000, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
        ic(5'b01000, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0);
        ic(5'b01010, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
        ic(5'b00101, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1);
        ic(5'b10000, 7'h05, 7'h05, 7'h00, 7'h00, 1'b1);
        ic(5'b10000, 7'h06, 7'h05, 7'h00, 7'h00, 1'b0);
        ic(5'b11000, 7'h05, 7'h05, 7'h00, 7'h00, 1'b0);
        ic(5'b11010, 7'h05, 7'h05, 7'h00, 7'h00, 1'b1);
        ic(5'b10000, 7'h06, 7'h05, 7'h09, 7'h08, 1'b1);
        ic(5'b10000, 7'h06, 7'h05, 7'h07, 7'h08, 1'b0);
        chk({15'h0000, irqB}, 16'h0001);
        summarize();
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule
